// ---- core/vam_defs.svh ----
// constants for the attribute mode, overscan and plane enable register bank
// What this block does
// - text mode, line graphics bit clear: ninth dot column shows background colour.
// - line graphics bit set: eighth font dot copied to ninth for codes C0..DF.
// - extended attributes: line graphics bit clear clips bold/shifted glyphs at cell edges.
// - mono bit set selects monochrome attributes outside overlap mode, clear selects colour attributes.
// - overlap text/graphics mode with mono bit set: background is palette entry 0.
// - bit 7 picks colour address bits 4/5 from palette or colour select field.
// - pixel width bit set: pixel data updates every second dot clock.
// - panning bit set lets line compare affect pixel panning and preset row scan.
// - bit 3 clear: attribute bit 7 is background intensity; set: it enables blinking.
// - mode register written at port 03C0, read at 03C1, with index 10 hex.
// - border lines between vertical blank start and display end show overscan colour.
// - extended modes add eight high border colour bits from overscan high register.
// - plane enable register: slow blink 7, half bright 6, status mux 5..4, planes 3..0.
// - mode register bit 4 is reserved with no function.
// - slow blink bit set halves the character blink rate.
// - half bright bit and half bright attribute blank alternate character scan lines.
// - each plane enable bit gates its own display plane, bit n for plane n.
`ifndef VAM_DEFS_SVH
`define VAM_DEFS_SVH

// ****************************************
// host ports and indices
// ****************************************
`define VAM_PORT_WRITE 16'h03C0
`define VAM_PORT_READ 16'h03C1
`define VAM_IDX_MODE 5'h10
`define VAM_IDX_OVERSCAN 5'h11
`define VAM_IDX_PLANE 5'h12
`define VAM_IDX_BORDER_HIGH 5'h15

// ****************************************
// field positions
// ****************************************
`define VAM_MODE_PAL_SRC 7
`define VAM_MODE_PIX_WIDTH 6
`define VAM_MODE_PAN_COMPAT 5
`define VAM_MODE_BLINK 3
`define VAM_MODE_LINE_GFX 2
`define VAM_MODE_MONO 1
`define VAM_MODE_GFX 0
`define VAM_MODE_RW_MASK 8'hEF
`define VAM_PLANE_SLOW_BLINK 7
`define VAM_PLANE_HALF_BRIGHT 6
`define VAM_INDEX_PAS 5

// ****************************************
// reset values and counts
// ****************************************
`define VAM_RESET_BYTE 8'h00
`define VAM_LINE_GFX_FIRST 8'hC0
`define VAM_LINE_GFX_LAST 8'hDF
`define VAM_NINTH_COL 4'h8
`define VAM_BLINK_FRAMES 5'h10

`endif

// ---- core/vam_pkg.sv ----
// types shared by the attribute register bank
package vam_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } vam_io_t;

   typedef struct packed {
      logic text_mode;
      logic ext_attr;
      logic ext_overlap;
      logic ext_display;
      logic [7:0] char_code;
      logic [7:0] attr;
      logic [3:0] dot_col;
      logic font_dot;
      logic font_dot8;
      logic spill_dot;
      logic half_bright_attr;
      logic scan_odd;
      logic [3:0] planes;
      logic [5:0] pal_entry;
      logic border;
   } vam_dot_t;

   typedef struct packed {
      logic line_compare;
      logic [3:0] pan;
      logic [4:0] preset_row;
   } vam_pan_t;

endpackage

// ---- core/vam_blink_gen.sv ----
// frame counting blink phase generator
`timescale 1ns/1ns
`include "vam_defs.svh"
module vam_blink_gen (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic frame_pulse,
   input wire logic slow_blink,
   // phase
   output logic blink_phase
);
   logic [5:0] count;
   logic [5:0] limit;

   // slow blink doubles the frame count per phase
   assign limit = slow_blink ? {`VAM_BLINK_FRAMES, 1'b0} - 6'h01
                             : {1'b0, `VAM_BLINK_FRAMES} - 6'h01;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 6'h00;
         blink_phase <= 1'b0;
      end else if (frame_pulse) begin
         if (count >= limit) begin
            count <= 6'h00;
            blink_phase <= ~blink_phase;
         end else begin
            count <= count + 6'h01;
         end
      end
   end

   property p_blink_toggle;
      @(posedge clk) disable iff (!rst_n)
      (blink_phase != $past(blink_phase)) |-> ($past(count) == $past(limit));
   endproperty
   a_blink_toggle: assert property (p_blink_toggle)
      else $error("blink phase toggled before frame limit");
endmodule

// ---- core/vam_dot_select.sv ----
// per dot foreground selection: ninth column and clipping
`timescale 1ns/1ns
`include "vam_defs.svh"
module vam_dot_select (
   // control
   input wire logic line_gfx,
   input wire logic text_mode,
   input wire logic ext_attr,
   // dot inputs
   input wire logic [7:0] char_code,
   input wire logic [3:0] dot_col,
   input wire logic font_dot,
   input wire logic font_dot8,
   input wire logic spill_dot,
   // result
   output logic fg_dot
);
   logic is_gfx_code;

   assign is_gfx_code = (char_code >= `VAM_LINE_GFX_FIRST) && (char_code <= `VAM_LINE_GFX_LAST);

   always_comb begin
      fg_dot = font_dot;
      if (ext_attr) begin
         // spill beyond the cell only survives when clipping is off
         fg_dot = font_dot | (spill_dot & line_gfx);
      end else if (text_mode && dot_col == `VAM_NINTH_COL) begin
         fg_dot = line_gfx & is_gfx_code & font_dot8;
      end
   end
endmodule

// ---- core/vam_attr_bank.sv ----
// attribute mode, overscan and plane enable registers with the dot path they steer
`timescale 1ns/1ns
`include "vam_defs.svh"
module vam_attr_bank (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host port
   input wire vam_pkg::vam_io_t io,
   input wire logic index_flop_clear,
   output logic [7:0] io_rdata,
   output logic io_rdata_valid,
   // dot stream
   input wire vam_pkg::vam_dot_t dot,
   input wire logic frame_pulse,
   input wire logic [1:0] color_select_bits_4_5,
   input wire logic [1:0] color_select_bits_6_7,
   input wire vam_pkg::vam_pan_t pan_in,
   // pixel outputs
   output logic [7:0] dac_index,
   output logic [3:0] attr_index,
   output logic [15:0] border_color,
   output logic border_active,
   output logic mono_attr,
   output logic [1:0] diag_bits,
   output vam_pkg::vam_pan_t pan_out,
   // mode levels
   output logic graphics_mode_select,
   output logic [1:0] video_status_mux
);
   // ****************************************
   // index flop and registers
   // ****************************************
   logic data_phase;
   logic [4:0] attribute_index_field;
   logic pal_addr_src;
   logic [7:0] attribute_mode_control;
   logic [7:0] overscan_color;
   logic [7:0] color_plane_enable;
   logic [7:0] border_color_high_bits;
   logic wr_index;
   logic wr_data;
   logic [7:0] next_rdata;

   assign wr_index = io.wr && io.addr == `VAM_PORT_WRITE && !data_phase;
   assign wr_data = io.wr && io.addr == `VAM_PORT_WRITE && data_phase;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_phase <= 1'b0;
      end else if (index_flop_clear) begin
         data_phase <= 1'b0;
      end else if (io.wr && io.addr == `VAM_PORT_WRITE) begin
         data_phase <= ~data_phase;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         attribute_index_field <= 5'h00;
         pal_addr_src <= 1'b0;
      end else if (wr_index) begin
         attribute_index_field <= io.wdata[4:0];
         pal_addr_src <= io.wdata[`VAM_INDEX_PAS];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         attribute_mode_control <= `VAM_RESET_BYTE;
         overscan_color <= `VAM_RESET_BYTE;
         color_plane_enable <= `VAM_RESET_BYTE;
         border_color_high_bits <= `VAM_RESET_BYTE;
      end else if (wr_data) begin
         unique case (attribute_index_field)
            `VAM_IDX_MODE: begin
               // bit 4 has no storage
               attribute_mode_control <= io.wdata & `VAM_MODE_RW_MASK;
            end
            `VAM_IDX_OVERSCAN: begin
               overscan_color <= io.wdata;
            end
            `VAM_IDX_PLANE: begin
               color_plane_enable <= io.wdata;
            end
            `VAM_IDX_BORDER_HIGH: begin
               border_color_high_bits <= io.wdata;
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (io.addr == `VAM_PORT_WRITE) begin
         next_rdata = {2'b00, pal_addr_src, attribute_index_field};
      end else begin
         unique case (attribute_index_field)
            `VAM_IDX_MODE: next_rdata = attribute_mode_control;
            `VAM_IDX_OVERSCAN: next_rdata = overscan_color;
            `VAM_IDX_PLANE: next_rdata = color_plane_enable;
            `VAM_IDX_BORDER_HIGH: next_rdata = border_color_high_bits;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // only the two attribute ports answer; other addresses leave the bus alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata <= 8'h00;
         io_rdata_valid <= 1'b0;
      end else begin
         io_rdata_valid <= io.rd && (io.addr == `VAM_PORT_READ || io.addr == `VAM_PORT_WRITE);
         if (io.rd && (io.addr == `VAM_PORT_READ || io.addr == `VAM_PORT_WRITE)) begin
            io_rdata <= next_rdata;
         end
      end
   end

   // ****************************************
   // mode fields
   // ****************************************
   logic palette_high_bits_source;
   logic pixel_width_select;
   logic panning_compat_enable;
   logic blink_or_intensity_select;
   logic line_graphics_clip_bit;
   logic mono_black_background_bit;
   logic slow_blink_enable;
   logic half_bright_enable;
   logic [3:0] plane_enable_field;

   assign palette_high_bits_source = attribute_mode_control[`VAM_MODE_PAL_SRC];
   assign pixel_width_select = attribute_mode_control[`VAM_MODE_PIX_WIDTH];
   assign panning_compat_enable = attribute_mode_control[`VAM_MODE_PAN_COMPAT];
   assign blink_or_intensity_select = attribute_mode_control[`VAM_MODE_BLINK];
   assign line_graphics_clip_bit = attribute_mode_control[`VAM_MODE_LINE_GFX];
   assign mono_black_background_bit = attribute_mode_control[`VAM_MODE_MONO];
   assign graphics_mode_select = attribute_mode_control[`VAM_MODE_GFX];
   assign slow_blink_enable = color_plane_enable[`VAM_PLANE_SLOW_BLINK];
   assign half_bright_enable = color_plane_enable[`VAM_PLANE_HALF_BRIGHT];
   assign video_status_mux = color_plane_enable[5:4];
   assign plane_enable_field = color_plane_enable[3:0];

   // ****************************************
   // dot path
   // ****************************************
   logic blink_phase;
   logic fg_dot;
   logic fg_on;
   logic [3:0] bg_index;
   logic [3:0] next_attr_index;
   logic [7:0] next_dac_index;
   logic pixel_phase;
   logic pixel_load;

   vam_blink_gen u_blink (
      .clk(clk),
      .rst_n(rst_n),
      .frame_pulse(frame_pulse),
      .slow_blink(slow_blink_enable),
      .blink_phase(blink_phase)
   );

   vam_dot_select u_dot (
      .line_gfx(line_graphics_clip_bit),
      .text_mode(dot.text_mode),
      .ext_attr(dot.ext_attr),
      .char_code(dot.char_code),
      .dot_col(dot.dot_col),
      .font_dot(dot.font_dot),
      .font_dot8(dot.font_dot8),
      .spill_dot(dot.spill_dot),
      .fg_dot(fg_dot)
   );

   always_comb begin
      // attribute bit 7 is intensity unless blinking is enabled
      bg_index = blink_or_intensity_select ? {1'b0, dot.attr[6:4]} : dot.attr[7:4];
      if (dot.ext_overlap && mono_black_background_bit) begin
         bg_index = 4'h0;
      end
      fg_on = fg_dot;
      if (blink_or_intensity_select && dot.attr[7] && blink_phase) begin
         fg_on = 1'b0;
      end
      if (half_bright_enable && dot.half_bright_attr && dot.scan_odd) begin
         fg_on = 1'b0;
      end
      if (graphics_mode_select) begin
         next_attr_index = dot.planes & plane_enable_field;
      end else begin
         next_attr_index = (fg_on ? dot.attr[3:0] : bg_index) & plane_enable_field;
      end
      if (dot.border) begin
         next_dac_index = overscan_color;
      end else begin
         next_dac_index = {color_select_bits_6_7,
                           palette_high_bits_source ? color_select_bits_4_5
                                                    : dot.pal_entry[5:4],
                           dot.pal_entry[3:0]};
      end
   end

   // pixel width stretches each output pixel over two dot clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pixel_phase <= 1'b0;
      end else begin
         pixel_phase <= pixel_width_select ? ~pixel_phase : 1'b0;
      end
   end

   assign pixel_load = !pixel_width_select || pixel_phase;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         attr_index <= 4'h0;
         dac_index <= 8'h00;
         border_active <= 1'b0;
         mono_attr <= 1'b0;
      end else if (pixel_load) begin
         attr_index <= next_attr_index;
         dac_index <= next_dac_index;
         border_active <= dot.border;
         mono_attr <= mono_black_background_bit && !dot.ext_overlap;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         border_color <= 16'h0000;
      end else begin
         // high byte only counts in extended display modes
         border_color <= {dot.ext_display ? border_color_high_bits : 8'h00,
                          overscan_color};
      end
   end

   always_comb begin
      unique case (video_status_mux)
         2'b00: diag_bits = {dac_index[2], dac_index[0]};
         2'b01: diag_bits = {dac_index[5], dac_index[4]};
         2'b10: diag_bits = {dac_index[3], dac_index[1]};
         2'b11: diag_bits = {dac_index[7], dac_index[6]};
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pan_out <= '0;
      end else begin
         pan_out.line_compare <= pan_in.line_compare;
         if (panning_compat_enable && pan_in.line_compare) begin
            pan_out.pan <= 4'h0;
            pan_out.preset_row <= 5'h00;
         end else begin
            pan_out.pan <= pan_in.pan;
            pan_out.preset_row <= pan_in.preset_row;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_mode_write;
      @(posedge clk) disable iff (!rst_n)
      (wr_data && attribute_index_field == `VAM_IDX_MODE)
         |=> (attribute_mode_control == ($past(io.wdata) & `VAM_MODE_RW_MASK));
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode register did not take written value");

   property p_reserved_bit;
      @(posedge clk) disable iff (!rst_n)
      !attribute_mode_control[4];
   endproperty
   a_reserved_bit: assert property (p_reserved_bit)
      else $error("reserved mode bit is set");

   property p_readback;
      @(posedge clk) disable iff (!rst_n)
      (io.rd && io.addr == `VAM_PORT_READ && attribute_index_field == `VAM_IDX_PLANE)
         |=> io_rdata_valid && io_rdata == $past(color_plane_enable);
   endproperty
   a_readback: assert property (p_readback)
      else $error("plane enable read back wrong");

   property p_pixel_hold;
      @(posedge clk) disable iff (!rst_n)
      (pixel_width_select && !pixel_phase && $past(pixel_width_select))
         |=> $stable(dac_index) && $stable(attr_index);
   endproperty
   a_pixel_hold: assert property (p_pixel_hold)
      else $error("pixel changed on a hold cycle");

   property p_plane_gate;
      @(posedge clk) disable iff (!rst_n)
      pixel_load |=> (attr_index & ~$past(plane_enable_field)) == 4'h0;
   endproperty
   a_plane_gate: assert property (p_plane_gate)
      else $error("disabled plane reached output");

   property p_border_color;
      @(posedge clk) disable iff (!rst_n)
      (dot.border && pixel_load) |=> dac_index == $past(overscan_color);
   endproperty
   a_border_color: assert property (p_border_color)
      else $error("border not painted in overscan colour");

   property p_pan_reset;
      @(posedge clk) disable iff (!rst_n)
      (panning_compat_enable && pan_in.line_compare) |=> pan_out.pan == 4'h0;
   endproperty
   a_pan_reset: assert property (p_pan_reset)
      else $error("line compare did not clear panning");

   property p_pan_pass;
      @(posedge clk) disable iff (!rst_n)
      !panning_compat_enable |=> pan_out.pan == $past(pan_in.pan);
   endproperty
   a_pan_pass: assert property (p_pan_pass)
      else $error("panning altered with compatibility off");

   property p_pal_src;
      @(posedge clk) disable iff (!rst_n)
      (palette_high_bits_source && !dot.border && pixel_load)
         |=> dac_index[5:4] == $past(color_select_bits_4_5);
   endproperty
   a_pal_src: assert property (p_pal_src)
      else $error("colour select bits not used for address 5:4");

   property p_ninth_bg;
      @(posedge clk) disable iff (!rst_n)
      (dot.text_mode && !dot.ext_attr && dot.dot_col == `VAM_NINTH_COL
         && !line_graphics_clip_bit) |-> !fg_dot;
   endproperty
   a_ninth_bg: assert property (p_ninth_bg)
      else $error("ninth dot not background");

   c_mode_write: cover property (@(posedge clk) disable iff (!rst_n)
      wr_data && attribute_index_field == `VAM_IDX_MODE);
   c_pixel_double: cover property (@(posedge clk) disable iff (!rst_n)
      pixel_width_select && pixel_phase);
   c_border: cover property (@(posedge clk) disable iff (!rst_n)
      dot.border && dot.ext_display);
   c_blink_off: cover property (@(posedge clk) disable iff (!rst_n)
      blink_or_intensity_select && dot.attr[7] && blink_phase);
endmodule

// ---- testbench/vam_attr_bank_tb_top.sv ----
// self-checking bench for the attribute mode, overscan and plane enable bank
`timescale 1ns/1ns
`include "vam_defs.svh"
`define VAM_CHECK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module vam_attr_bank_tb_top;
   // flags: font_dot, font_dot8, spill, ext_attr, ext_overlap, half_bright, scan_odd, spare
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] plane;
      logic [7:0] attr;
      logic [7:0] code;
      logic [3:0] col;
      logic [7:0] flags;
      logic [3:0] exp;
   } vam_row_t;
   // clock, reset and ports
   logic clk;
   logic rst_n;
   vam_pkg::vam_io_t io;
   logic index_flop_clear;
   logic [7:0] io_rdata;
   logic io_rdata_valid;
   vam_pkg::vam_dot_t dot;
   logic frame_pulse;
   logic [1:0] cs45;
   logic [1:0] cs67;
   vam_pkg::vam_pan_t pan_in;
   logic [7:0] dac_index;
   logic [3:0] attr_index;
   logic [15:0] border_color;
   logic border_active;
   logic mono_attr;
   logic [1:0] diag_bits;
   vam_pkg::vam_pan_t pan_out;
   logic graphics_mode_select;
   logic [1:0] video_status_mux;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int cnt;
   logic [7:0] rd;
   vam_row_t rows [15] = '{
      '{8'h10, 8'h0F, 8'h0A, 8'hC5, 4'h8, 8'h40, 4'h0},
      '{8'h04, 8'h0F, 8'h0A, 8'hC5, 4'h8, 8'h40, 4'hA},
      '{8'h04, 8'h0F, 8'h0A, 8'hDF, 4'h8, 8'h40, 4'hA},
      '{8'h04, 8'h0F, 8'h0A, 8'hE0, 4'h8, 8'h40, 4'h0},
      '{8'h04, 8'h0F, 8'h0A, 8'hBF, 4'h8, 8'h40, 4'h0},
      '{8'h04, 8'h0F, 8'h0A, 8'h41, 4'h3, 8'h30, 4'hA},
      '{8'h00, 8'h0F, 8'h0A, 8'h41, 4'h3, 8'h30, 4'h0},
      '{8'h02, 8'h0F, 8'h3A, 8'h41, 4'h0, 8'h08, 4'h0},
      '{8'h00, 8'h0F, 8'h3A, 8'h41, 4'h0, 8'h08, 4'h3},
      '{8'h00, 8'h4F, 8'h0A, 8'h41, 4'h0, 8'h86, 4'h0},
      '{8'h00, 8'h4F, 8'h0A, 8'h41, 4'h0, 8'h84, 4'hA},
      '{8'h00, 8'h0F, 8'h8A, 8'h41, 4'h0, 8'h00, 4'h8},
      '{8'h08, 8'h0F, 8'h8A, 8'h41, 4'h0, 8'h00, 4'h0},
      '{8'h00, 8'h03, 8'h0A, 8'h41, 4'h0, 8'h80, 4'h2},
      '{8'h00, 8'h0C, 8'h0A, 8'h41, 4'h0, 8'h80, 4'h8}
   };

   vam_attr_bank dut_u (
      .clk(clk),
      .rst_n(rst_n),
      .io(io),
      .index_flop_clear(index_flop_clear),
      .io_rdata(io_rdata),
      .io_rdata_valid(io_rdata_valid),
      .dot(dot),
      .frame_pulse(frame_pulse),
      .color_select_bits_4_5(cs45),
      .color_select_bits_6_7(cs67),
      .pan_in(pan_in),
      .dac_index(dac_index),
      .attr_index(attr_index),
      .border_color(border_color),
      .border_active(border_active),
      .mono_attr(mono_attr),
      .diag_bits(diag_bits),
      .pan_out(pan_out),
      .graphics_mode_select(graphics_mode_select),
      .video_status_mux(video_status_mux)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // host port tasks
   // ****************************************
   // the flop is cleared first so every access starts in index phase
   task automatic put(input logic [7:0] d);
      @(negedge clk);
      io.wr = 1'b1;
      io.addr = `VAM_PORT_WRITE;
      io.wdata = d;
      @(negedge clk);
      io.wr = 1'b0;
   endtask

   task automatic select(input logic [4:0] idx);
      @(negedge clk);
      index_flop_clear = 1'b1;
      @(negedge clk);
      index_flop_clear = 1'b0;
      put({3'h1, idx});
   endtask

   task automatic regw(input logic [4:0] idx, input logic [7:0] d);
      select(idx);
      put(d);
   endtask

   task automatic regr(input logic [4:0] idx, input logic [15:0] a, output logic [7:0] d);
      int n;
      select(idx);
      @(negedge clk);
      io.rd = 1'b1;
      io.addr = a;
      n = 0;
      @(negedge clk);
      io.rd = 1'b0;
      while (io_rdata_valid !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      `VAM_CHECK(io_rdata_valid, 1'b1)
      d = io_rdata;
   endtask

   task automatic frames(input int n);
      repeat (n) begin
         @(negedge clk);
         frame_pulse = 1'b1;
         @(negedge clk);
         frame_pulse = 1'b0;
      end
      // registered index lags the phase flip by one load
      @(negedge clk);
   endtask

   // width 1 must hide a dot stream that flips every cycle
   task automatic toggle_run(output int c);
      logic prev;
      c = 0;
      prev = border_active;
      for (int j = 0; j < 10; j++) begin
         dot.border = ~dot.border;
         @(negedge clk);
         if (j > 1 && border_active !== prev) c++;
         prev = border_active;
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         summarize();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      io = '0;
      index_flop_clear = 1'b0;
      dot = '0;
      frame_pulse = 1'b0;
      cs45 = 2'h0;
      cs67 = 2'h0;
      pan_in = '0;
      repeat (3) @(negedge clk);
      `VAM_CHECK(border_color, 16'h0000)
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         regw(`VAM_IDX_MODE, rows[i].mode);
         regw(`VAM_IDX_PLANE, rows[i].plane);
         regr(`VAM_IDX_MODE, `VAM_PORT_READ, rd);
         `VAM_CHECK(rd, rows[i].mode & `VAM_MODE_RW_MASK)
         regr(`VAM_IDX_PLANE, `VAM_PORT_READ, rd);
         `VAM_CHECK(rd, rows[i].plane)
         dot = '0;
         dot.text_mode = 1'b1;
         dot.char_code = rows[i].code;
         dot.attr = rows[i].attr;
         dot.dot_col = rows[i].col;
         {dot.font_dot, dot.font_dot8, dot.spill_dot, dot.ext_attr, dot.ext_overlap,
            dot.half_bright_attr, dot.scan_odd} = rows[i].flags[7:1];
         @(negedge clk);
         `VAM_CHECK(attr_index, rows[i].exp)
      end
      // blink phase flips every 16 frames, every 32 with slow blink
      regw(`VAM_IDX_PLANE, 8'h0F);
      regw(`VAM_IDX_MODE, 8'h08);
      dot.attr = 8'h8A;
      dot.font_dot = 1'b1;
      frames(16);
      `VAM_CHECK(attr_index, 4'h0)
      frames(16);
      `VAM_CHECK(attr_index, 4'hA)
      regw(`VAM_IDX_PLANE, 8'h8F);
      frames(16);
      `VAM_CHECK(attr_index, 4'hA)
      frames(16);
      `VAM_CHECK(attr_index, 4'h0)
      // unmapped index and index readback
      regw(5'h13, 8'h77);
      regr(5'h13, `VAM_PORT_READ, rd);
      `VAM_CHECK(rd, 8'h00)
      regr(5'h13, `VAM_PORT_WRITE, rd);
      `VAM_CHECK(rd, 8'h33)
      // border colour
      regw(`VAM_IDX_OVERSCAN, 8'h5A);
      regw(`VAM_IDX_BORDER_HIGH, 8'hC3);
      regr(`VAM_IDX_BORDER_HIGH, `VAM_PORT_READ, rd);
      `VAM_CHECK(rd, 8'hC3)
      dot = '0;
      dot.border = 1'b1;
      dot.ext_display = 1'b1;
      @(negedge clk);
      `VAM_CHECK(border_active, 1'b1)
      `VAM_CHECK(dac_index, 8'h5A)
      `VAM_CHECK(border_color, 16'hC35A)
      dot.ext_display = 1'b0;
      @(negedge clk);
      `VAM_CHECK(border_color, 16'h005A)
      // palette high bits source, graphics dots
      dot = '0;
      dot.pal_entry = 6'h2B;
      cs45 = 2'h1;
      cs67 = 2'h2;
      regw(`VAM_IDX_MODE, 8'h81);
      @(negedge clk);
      `VAM_CHECK(dac_index[7:4], 4'h9)
      `VAM_CHECK(graphics_mode_select, 1'b1)
      regw(`VAM_IDX_MODE, 8'h01);
      @(negedge clk);
      `VAM_CHECK(dac_index[7:4], 4'hA)
      // mono interpretation
      regw(`VAM_IDX_MODE, 8'h02);
      @(negedge clk);
      `VAM_CHECK(mono_attr, 1'b1)
      dot.ext_overlap = 1'b1;
      @(negedge clk);
      `VAM_CHECK(mono_attr, 1'b0)
      // back to mono looking input so only the mode bit can clear it
      dot.ext_overlap = 1'b0;
      regw(`VAM_IDX_MODE, 8'h00);
      @(negedge clk);
      `VAM_CHECK(mono_attr, 1'b0)
      // panning compatibility
      pan_in = 10'h2AA;
      regw(`VAM_IDX_MODE, 8'h20);
      @(negedge clk);
      // line compare flag itself still passes through
      `VAM_CHECK(pan_out, 10'h200)
      pan_in = 10'h0AA;
      @(negedge clk);
      `VAM_CHECK(pan_out, 10'h0AA)
      pan_in = 10'h2AA;
      regw(`VAM_IDX_MODE, 8'h00);
      @(negedge clk);
      `VAM_CHECK(pan_out, 10'h2AA)
      // pixel width
      toggle_run(cnt);
      `VAM_CHECK(cnt, 8)
      regw(`VAM_IDX_MODE, 8'h40);
      toggle_run(cnt);
      `VAM_CHECK(cnt, 0)
      regw(`VAM_IDX_PLANE, 8'h25);
      `VAM_CHECK(video_status_mux, 2'h2)
      `VAM_CHECK(dac_index, 8'hAB)
      `VAM_CHECK(diag_bits, 2'h3)
      // reset in mid-run clears the bank
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      regr(`VAM_IDX_MODE, `VAM_PORT_READ, rd);
      `VAM_CHECK(rd, `VAM_RESET_BYTE)
      regr(`VAM_IDX_OVERSCAN, `VAM_PORT_READ, rd);
      `VAM_CHECK(rd, `VAM_RESET_BYTE)
      summarize();
   end
endmodule
